// file: verilog/ssq_pkg.sv
// Purpose: Shared constants and carrier types for the smoke alarm sequencer.
// Assumes: mclk runs at 20 MHz; one oscillator period is built from mclk cycles.
// Notes: Oscillator-tick slots are positions inside a free-running 4096-tick frame.
`default_nettype none

package ssq_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int OSC_PERIOD_US = 7900;
	localparam int OSC_DIV_DEFAULT = OSC_PERIOD_US * 1000 / CLK_PERIOD_NS;
	localparam int EMIT_WIDTH_US = 105;
	localparam int EMIT_CYCLES = EMIT_WIDTH_US * 1000 / CLK_PERIOD_NS;
	localparam int MUTE_WINDOW_MIN = 8;
	localparam int MUTE_TICKS_DEFAULT = MUTE_WINDOW_MIN * 60 * 1000000 / OSC_PERIOD_US;
	localparam int IO_CONFIRM_MS = 10;
	localparam int IO_CONFIRM_RAW = IO_CONFIRM_MS * 1000 / OSC_PERIOD_US;
	localparam int IO_CONFIRM_TICKS = (IO_CONFIRM_RAW < 1) ? 1 : IO_CONFIRM_RAW;

	// ************************************************************
	// Slots in the oscillator-tick frame
	// ************************************************************
	localparam logic [9:0] SMOKE_SLOT = 10'h000;
	localparam logic [11:0] CHAMBER_SLOT = 12'h220;
	localparam logic [11:0] LOWSUP_SLOT = 12'h640;
	localparam logic [6:0] FAST_SLOT = 7'h00;
	localparam logic [6:0] IO_SLOT = 7'h10;
	localparam logic [11:0] CHIRP_SLOT = 12'h400;
	localparam logic [11:0] LED_SLOW_SLOT = 12'h010;
	localparam logic [7:0] LED_FAST_SLOT = 8'h08;
	localparam logic [4:0] MEM_CHIRP_SLOT = 5'h00;
	localparam logic [4:0] MOD_ON_TICKS = 5'h18;
	localparam logic [1:0] TEST_ALARM_PULSE = 2'h1;
	localparam logic [1:0] TEST_EXIT_PULSES = 2'h2;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		MD_STANDBY, MD_SPEEDUP, MD_LOCAL, MD_MUTE,
		MD_REMOTE, MD_TEST, MD_TESTEXIT, MD_MEMTEST
	} ssq_mode_t;

	typedef enum logic [1:0] {PR_NONE, PR_SMOKE, PR_CHAMBER, PR_TEST} ssq_probe_t;

	typedef struct packed {
		logic testReq;
		logic muteReq;
		logic smoke;
		logic highSmoke;
		logic lowSupply;
		logic io;
	} ssq_pins_t;

	typedef struct packed {
		logic emitterPulse;
		logic strobe;
		logic highGain;
		logic highSmokeRef;
		logic lowSupplyLoad;
		logic hornBrass;
		logic hornSilver;
		logic led_n;
		logic ioOut;
		logic ioOe;
		logic timedHornSilence;
	} ssq_drive_t;

	typedef struct packed {
		ssq_pins_t sync1;
		ssq_pins_t sync2;
		logic ioPrev;
		logic ioEdge;
		logic ioConfirm;
		logic [17:0] oscDiv;
		logic [11:0] oscCnt;
		ssq_mode_t mode;
		ssq_probe_t probe;
		logic lowLoadNow;
		logic alarmMem;
		logic lowBat;
		logic chamberBad;
		logic [1:0] testPulses;
		logic testAlarm;
		logic [15:0] muteLeft;
		ssq_drive_t drive;
	} ssq_state_t;

endpackage

`default_nettype wire

// file: verilog/ssq_smoke_alarm_sequencer.sv
// Purpose: Digital sequencer of a photoelectric smoke alarm: probe timing,
//          remote line filtering, horn patterns, LED rates, test, memory and mute.
// Assumes: Analog comparators and the three-level test/mute decode sit outside.
// Notes: One oscillator period is OSC_DIV mclk cycles; all timing but the emitter width counts in ticks.
//        Every mode and probe decision is taken on the mclk edge that ends an oscillator period.
//        Outputs are registered copies of the next state, so each output level
//        changes together with the mode that asks for it.
//        A short divider for simulation squeezes the emitter to one mclk cycle.
`timescale 1ns/1ps
`default_nettype none

module ssq_smoke_alarm_sequencer
	import ssq_pkg::*;
#(
	parameter int OSC_DIV = OSC_DIV_DEFAULT,
	parameter int MUTE_TICKS = MUTE_TICKS_DEFAULT
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Pins and comparator results
	input wire ssq_pkg::ssq_pins_t pinsIn,
	// Drivers
	output var ssq_pkg::ssq_drive_t drive
);
	import ssq_pkg::*;

	localparam logic [17:0] DIV_LAST = 18'(OSC_DIV - 1);
	// The emitter occupies the tail of the strobe period. When the period is
	// shorter than the emitter width, only its last mclk cycle is used, so the
	// start never wraps below zero.
	localparam logic [17:0] EMIT_START = (OSC_DIV > EMIT_CYCLES)
		? 18'(OSC_DIV - EMIT_CYCLES)
		: DIV_LAST;
	localparam logic [15:0] MUTE_LOAD = 16'(MUTE_TICKS);
	localparam logic [1:0] CONFIRM_LOAD = 2'(IO_CONFIRM_TICKS);

	ssq_state_t s;
	ssq_state_t next_s;

	// ************************************************************
	// Decoding helpers
	// ************************************************************

	// Modes in which smoke is probed at the speed-up rate.
	function automatic logic isFast(input ssq_mode_t m);
		isFast = (m == MD_SPEEDUP) || (m == MD_LOCAL) || (m == MD_MUTE);
	endfunction

	// Modes belonging to a pushbutton test.
	function automatic logic isTest(input ssq_mode_t m);
		isTest = (m == MD_TEST) || (m == MD_TESTEXIT) || (m == MD_MEMTEST);
	endfunction

	// Modes in which the remote line is watched.
	function automatic logic watchesIo(input ssq_mode_t m);
		watchesIo = (m == MD_STANDBY) || (m == MD_SPEEDUP) || (m == MD_MUTE);
	endfunction

	logic tick;
	logic ioRise;
	logic [11:0] nc;
	logic smokeSeen;
	logic highSeen;
	logic toneOn;
	logic chirpOn;
	logic ledPulse;
	logic ioDrive;
	logic [1:0] confirmLeft;

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb
	begin
		next_s = s;
		confirmLeft = 2'h0;
		tick = (s.oscDiv == DIV_LAST);
		nc = s.oscCnt + 12'h001;
		smokeSeen = s.sync2.smoke;
		highSeen = s.sync2.highSmoke;

		// Input synchronisers.
		next_s.sync1 = pinsIn;
		next_s.sync2 = s.sync1;
		next_s.ioPrev = s.sync2.io;

		// Edge capture. The line is ignored while this unit drives it, so
		// that its own alarm does not come back to it as a remote one.
		ioRise = s.sync2.io && !s.ioPrev && !s.drive.ioOe;
		if (ioRise)
			next_s.ioEdge = 1'b1;

		// Oscillator divider and tick frame.
		next_s.oscDiv = tick ? 18'h0_0000 : s.oscDiv + 18'h0_0001;

		if (tick)
		begin
			next_s.oscCnt = nc;

			// Results of the probe that ends with this tick.
			if (s.lowLoadNow)
				next_s.lowBat = s.sync2.lowSupply;
			if (s.probe == PR_CHAMBER)
				next_s.chamberBad = !smokeSeen;

			// Mode sequencing. Smoke climbs from standby through speed-up to
			// the local alarm; a smoke-probe miss in speed-up, local or mute falls back to standby.
			// Mute is a silenced local alarm with its own window. A remote
			// alarm holds until the line is seen low at its sampling slot.
			// The pushbutton test runs its own probe slots and leaves through
			// the exit mode, which counts the closing probes; the memory test
			// returns straight to standby on release.
			case (s.mode)
				MD_STANDBY:
				begin
					if (s.probe == PR_SMOKE && smokeSeen)
						next_s.mode = MD_SPEEDUP;
				end
				MD_SPEEDUP:
				begin
					if (s.probe == PR_SMOKE)
					begin
						next_s.mode = smokeSeen ? MD_LOCAL : MD_STANDBY;
						if (smokeSeen)
							next_s.alarmMem = 1'b1;
					end
				end
				MD_LOCAL:
				begin
					if (s.probe == PR_SMOKE && !smokeSeen)
						next_s.mode = MD_STANDBY;
				end
				MD_MUTE:
				begin
					if (s.probe == PR_SMOKE && !smokeSeen)
					begin
						next_s.mode = MD_STANDBY;
						next_s.muteLeft = 16'h0000;
					end
					else if (s.probe == PR_SMOKE && highSeen)
						next_s.mode = MD_LOCAL;
					else if (s.muteLeft == 16'h0000)
						next_s.mode = MD_LOCAL;
					else
						next_s.muteLeft = s.muteLeft - 16'h0001;
				end
				MD_REMOTE:
				begin
					if (nc[6:0] == IO_SLOT && !s.sync2.io)
						next_s.mode = MD_STANDBY;
					if (s.probe == PR_SMOKE && smokeSeen)
						next_s.mode = MD_LOCAL;
				end
				MD_TEST:
				begin
					if (s.probe == PR_TEST)
					begin
						if (s.testPulses != 2'h3)
							next_s.testPulses = s.testPulses + 2'h1;
						if (s.testPulses >= TEST_ALARM_PULSE && smokeSeen)
							next_s.testAlarm = 1'b1;
					end
					if (!s.sync2.testReq)
					begin
						next_s.mode = MD_TESTEXIT;
						next_s.testPulses = 2'h0;
						next_s.alarmMem = 1'b0;
					end
				end
				MD_TESTEXIT:
				begin
					if (s.probe == PR_TEST)
					begin
						next_s.testPulses = s.testPulses + 2'h1;
						if (s.testPulses + 2'h1 == TEST_EXIT_PULSES)
						begin
							next_s.mode = MD_STANDBY;
							next_s.testAlarm = 1'b0;
							next_s.testPulses = 2'h0;
						end
					end
				end
				MD_MEMTEST:
				begin
					if (!s.sync2.testReq)
					begin
						next_s.alarmMem = 1'b0;
						next_s.mode = MD_STANDBY;
					end
				end
				default:
				begin
					next_s.mode = MD_STANDBY;
				end
			endcase

			// Remote line: first sample, then confirmation. A single glitch
			// on the line sets the edge flag but fails the second look, so
			// it never starts an alarm on its own.
			// Remote line: first sample, then confirmation.
			if (s.ioConfirm)
			begin
				next_s.ioConfirm = 1'b0;
				if (s.sync2.io && watchesIo(next_s.mode))
					next_s.mode = MD_REMOTE;
			end
			else if (nc[6:0] == IO_SLOT && watchesIo(s.mode) && s.ioEdge)
			begin
				// An edge landing on the sampling cycle waits for the next sample.
				next_s.ioEdge = ioRise;
				confirmLeft = CONFIRM_LOAD;
				next_s.ioConfirm = (confirmLeft != 2'h0);
			end

			// Pushbutton has priority over mute and cancels it.
			if (s.sync2.testReq && !isTest(s.mode))
			begin
				next_s.mode = s.alarmMem ? MD_MEMTEST : MD_TEST;
				next_s.muteLeft = 16'h0000;
				next_s.testPulses = 2'h0;
				next_s.testAlarm = 1'b0;
				next_s.ioConfirm = 1'b0;
			end
			else if (s.sync2.muteReq && !s.sync2.testReq && s.mode == MD_LOCAL)
			begin
				next_s.mode = MD_MUTE;
				next_s.muteLeft = MUTE_LOAD;
			end

			// Schedule the probe for the coming oscillator period. At most
			// one probe runs per period; test probes win over smoke probes,
			// and the chamber probe only runs in quiet standby.
			// Schedule the probe for the coming oscillator period.
			next_s.probe = PR_NONE;
			if (next_s.mode == MD_TEST || next_s.mode == MD_TESTEXIT)
			begin
				if (nc[6:0] == FAST_SLOT)
					next_s.probe = PR_TEST;
			end
			else if (next_s.mode == MD_MEMTEST)
				next_s.probe = PR_NONE;
			else if (isFast(next_s.mode) && nc[6:0] == FAST_SLOT)
				next_s.probe = PR_SMOKE;
			else if (nc[9:0] == SMOKE_SLOT)
				next_s.probe = PR_SMOKE;
			else if (nc == CHAMBER_SLOT && next_s.mode == MD_STANDBY)
				next_s.probe = PR_CHAMBER;

			// Low-supply load only in quiet standby on its own slot.
			next_s.lowLoadNow = (nc == LOWSUP_SLOT) && (next_s.mode == MD_STANDBY)
				&& (next_s.probe == PR_NONE) && !next_s.testAlarm;
		end

		// ********************************************************
		// Output decode from the next state
		// ********************************************************
		// Decoding the next state rather than the current one lets every
		// output come straight from the state register without a cycle
		// of lag behind the mode change.
		toneOn = ((next_s.mode == MD_LOCAL) || (next_s.mode == MD_REMOTE)
			|| next_s.testAlarm) && (next_s.oscCnt[4:0] < MOD_ON_TICKS);
		chirpOn = 1'b0;
		if (next_s.mode == MD_STANDBY && (next_s.lowBat || next_s.chamberBad)
			&& next_s.oscCnt == CHIRP_SLOT && !next_s.lowLoadNow)
			chirpOn = 1'b1;
		if (next_s.mode == MD_MEMTEST && next_s.oscCnt[4:0] == MEM_CHIRP_SLOT)
			chirpOn = 1'b1;

		case (next_s.mode)
			MD_STANDBY, MD_SPEEDUP:
				ledPulse = (next_s.oscCnt == LED_SLOW_SLOT);
			MD_REMOTE:
				ledPulse = 1'b0;
			default:
				ledPulse = (next_s.oscCnt[7:0] == LED_FAST_SLOT);
		endcase

		ioDrive = (next_s.mode == MD_LOCAL) || next_s.testAlarm;

		next_s.drive.strobe = (next_s.probe != PR_NONE);
		next_s.drive.emitterPulse = (next_s.probe != PR_NONE)
			&& (next_s.oscDiv >= EMIT_START);
		next_s.drive.highGain = (next_s.probe == PR_CHAMBER)
			|| (next_s.mode == MD_TEST);
		next_s.drive.highSmokeRef = (next_s.mode == MD_MUTE);
		next_s.drive.lowSupplyLoad = next_s.lowLoadNow;
		next_s.drive.hornBrass = toneOn || chirpOn;
		next_s.drive.hornSilver = toneOn || chirpOn;
		next_s.drive.led_n = !ledPulse;
		next_s.drive.ioOut = ioDrive;
		next_s.drive.ioOe = ioDrive;
		next_s.drive.timedHornSilence = (next_s.mode == MD_MUTE);
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Reset clears every counter and leaves the shared line undriven and the
	// LED dark, so a supply change never signals to the other units.
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s <= '0;
			s.drive.led_n <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign drive = s.drive;

endmodule

`default_nettype wire

// file: sim/ssq_remote_unit.sv
// Purpose: Remote detector unit on the shared alarm line.
// Assumes: The line has a pull-down, so a released line reads low.
// Notes: A send pulse raises the line for hold mclk cycles.
`timescale 1ns/1ps
`default_nettype none
module ssq_remote_unit
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Request
	input wire logic send,
	input wire logic [15:0] hold,
	// Line drive
	output logic lineOut
);
	logic [15:0] left;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			left <= 16'h0000;
		else if (send)
			left <= hold;
		else if (left != 16'h0000)
			left <= left - 16'h0001;
	end
	assign lineOut = left != 16'h0000;
endmodule
`default_nettype wire

// file: sim/ssq_sequencer_chk.sv
// Purpose: Port-level assertions for the smoke alarm sequencer.
// Assumes: One clock domain with asynchronous active-low reset.
// Notes: Release bounds suit a short oscillator divider.
`timescale 1ns/1ps
`default_nettype none
module ssq_sequencer_chk
	import ssq_pkg::*;
#(
	parameter int OSC_DIV = 8,
	parameter int MUTE_TICKS = 40
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Observed ports
	input wire ssq_pkg::ssq_pins_t pinsIn,
	input wire ssq_pkg::ssq_drive_t drive
);
	int ledLow;
	int muteLen;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ledLow <= 0;
			muteLen <= 0;
		end
		else
		begin
			ledLow <= drive.led_n ? 0 : ledLow + 1;
			muteLen <= drive.timedHornSilence ? muteLen + 1 : 0;
		end
	end
	sequence testReleased;
		$fell(pinsIn.testReq) ##1 !pinsIn.testReq [*2];
	endsequence
	AST_EMIT_IN: assert property (drive.emitterPulse |-> drive.strobe)
		else $error("emitter outside strobe");
	AST_EMIT_END: assert property ($fell(drive.emitterPulse) |-> $fell(drive.strobe))
		else $error("emitter did not end with strobe");
	AST_RST_IO: assert property ($rose(rst_n) |-> !drive.ioOe && drive.led_n)
		else $error("line driven at reset release");
	AST_LED_W: assert property ($rose(drive.led_n) |-> ledLow == OSC_DIV)
		else $error("led pulse width wrong");
	AST_GAIN_OFF: assert property (testReleased |-> ##[1:40] !drive.highGain)
		else $error("gain not restored");
	AST_LOAD: assert property (drive.lowSupplyLoad |->
		!(drive.strobe || drive.emitterPulse || drive.hornBrass))
		else $error("load overlaps activity");
	AST_HORN_PAIR: assert property (drive.hornBrass == drive.hornSilver)
		else $error("horn halves differ");
	AST_MUTE_OK: assert property ($rose(drive.timedHornSilence) |-> $past(drive.ioOe))
		else $error("mute outside local smoke");
	AST_MUTE_SIL: assert property (drive.timedHornSilence |->
		!drive.hornBrass && drive.highSmokeRef)
		else $error("mute not silent");
	AST_MUTE_LEN: assert property (muteLen <= (MUTE_TICKS + 2) * OSC_DIV)
		else $error("mute window too long");
endmodule
bind ssq_smoke_alarm_sequencer ssq_sequencer_chk #(.OSC_DIV(OSC_DIV), .MUTE_TICKS(MUTE_TICKS))
	chk (.mclk(mclk), .rst_n(rst_n), .pinsIn(pinsIn), .drive(drive));
`default_nettype wire

// file: sim/testbench.sv
// Purpose: Self-checking bench for the smoke alarm sequencer.
// Assumes: Short oscillator divider and mute window keep the run brief.
// Notes: The shared line is a wired-OR of the unit model and the design.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssq_pkg::*;
	localparam int DIV = 8;
	localparam int HORN = 5;
	localparam int OE = 1;
	localparam int GAIN = 8;
	localparam int LED = 3;
	localparam int MUTE = 0;
	logic mclk;
	logic rst_n;
	logic tReq, mReq, smk, hSmk, send;
	logic [15:0] hold;
	integer seed;
	int n_mismatch;
	int comparisons;
	int n;
	wire logic unitOut;
	wire logic lineIo;
	wire ssq_pkg::ssq_pins_t pinsW;
	wire ssq_pkg::ssq_drive_t dv;
	assign lineIo = unitOut | (dv.ioOe & dv.ioOut);
	// At high gain the chamber background reads as smoke.
	assign pinsW = {tReq, mReq, smk | dv.highGain, hSmk, 1'b0, lineIo};
	ssq_smoke_alarm_sequencer #(.OSC_DIV(DIV), .MUTE_TICKS(1000)) dut (.mclk(mclk),
		.rst_n(rst_n), .pinsIn(pinsW), .drive(dv));
	ssq_remote_unit unit (.mclk(mclk), .rst_n(rst_n), .send(send), .hold(hold),
		.lineOut(unitOut));
	function automatic int ticks(input int t);
		return t * DIV;
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic waitBit(input int b, input logic v, input int lim);
		int k;
		k = 0;
		while (dv[b] !== v && k < lim)
		begin
			@(negedge mclk);
			k++;
		end
		check(dv[b], v);
	endtask
	task automatic seen(input int b, input logic v, input int lim, output int h);
		h = 0;
		repeat (lim)
		begin
			@(negedge mclk);
			if (dv[b] === v)
				h++;
		end
	endtask
	task automatic gap(input int b, input logic v, output int c);
		logic p;
		repeat (2)
		begin
			c = 0;
			do
			begin
				p = dv[b];
				@(negedge mclk);
				c++;
			end
			while (!(dv[b] === v && p !== v) && c < 70000);
		end
	endtask
	task automatic pulseSend(input logic [15:0] h);
		hold = h;
		send = 1;
		@(negedge mclk);
		send = 0;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	initial
	begin
		#(90000 * 50);
		n_mismatch++;
		finish_test;
	end
	initial
	begin
		seed = 32'hd17a_a075;
		{tReq, mReq, smk, hSmk, send} = 5'h00;
		hold = 16'h0000;
		n_mismatch = 0;
		comparisons = 0;
		rst_n = 0;
		repeat (2) @(negedge mclk);
		check(dv.ioOe, 1'b0);
		check(dv.led_n, 1'b1);
		rst_n = 1;
		repeat (300)
		begin
			@(negedge mclk);
			mReq = 1'($random(seed));
			hSmk = 1'($random(seed));
		end
		check(dv.timedHornSilence, 1'b0);
		{mReq, hSmk} = 2'h0;
		$display("test mute refusal done");
		tReq = 1;
		smk = 1;
		waitBit(GAIN, 1, ticks(3));
		waitBit(HORN, 1, ticks(300));
		check(dv.ioOe, 1'b1);
		{tReq, smk} = 2'h0;
		waitBit(GAIN, 0, ticks(3));
		waitBit(OE, 0, ticks(400));
		$display("test pushbutton done");
		pulseSend(16'h0003);
		seen(HORN, 1, ticks(140), n);
		check(n, 0);
		pulseSend(16'h1000);
		waitBit(HORN, 1, ticks(140));
		seen(LED, 0, ticks(100), n);
		check(n, 0);
		repeat (ticks(700)) @(negedge mclk);
		seen(HORN, 1, ticks(40), n);
		check(n, 0);
		$display("test remote done");
		smk = 1;
		waitBit(OE, 1, ticks(1300));
		gap(LED, 0, n);
		check(n, ticks(256));
		mReq = 1;
		waitBit(MUTE, 1, ticks(3));
		mReq = 0;
		check(dv.highSmokeRef, 1'b1);
		gap(LED, 0, n);
		check(n, ticks(256));
		hSmk = 1;
		waitBit(MUTE, 0, ticks(140));
		waitBit(HORN, 1, ticks(40));
		{smk, hSmk} = 2'h0;
		waitBit(OE, 0, ticks(300));
		$display("test local mute done");
		tReq = 1;
		gap(HORN, 1, n);
		check(n, ticks(32));
		tReq = 0;
		repeat (ticks(3)) @(negedge mclk);
		tReq = 1;
		smk = 1;
		waitBit(OE, 1, ticks(300));
		{tReq, smk} = 2'h0;
		waitBit(OE, 0, ticks(400));
		$display("test memory done");
		finish_test;
	end
endmodule
`default_nettype wire
